//--- src/sbe_exec_unit.sv
// execution of increment-skip, decrement-skip, absolute jump and or-literal
`default_nettype none

module sbe_exec_unit (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// instruction stream from fetch
	input wire sbe_pkg::sbe_instr_s instr,
	output logic instr_ready,
	// file register port
	output sbe_pkg::sbe_file_req_s file_req,
	input wire logic [sbe_pkg::DATA_W-1:0] file_rdata,
	// high-address latch
	input wire logic [sbe_pkg::LATCH_W-1:0] pc_high_latch,
	// program counter load
	output sbe_pkg::sbe_pc_s pc_out,
	// working register and zero flag
	output logic [sbe_pkg::DATA_W-1:0] acc,
	output logic zero_flag,
	output logic zero_we,
	// slot reporting
	output logic nop_slot,
	output logic unknown_op
);

	import sbe_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode of the incoming word

	logic accept;
	logic is_dec;
	logic is_inc;
	logic is_jump;
	logic is_or;
	logic [FADDR_W-1:0] dec_addr;
	logic dec_dest;
	logic [DATA_W-1:0] dec_lit8;
	logic [JUMP_LIT_W-1:0] dec_lit11;
	sbe_state_e state;
	sbe_state_e next_state;

	always_comb
	begin
		accept = instr.valid & instr_ready;
		is_dec = (instr.word[OPC6_HI:OPC6_LO] == OPC_DEC_SKIP);
		is_inc = (instr.word[OPC6_HI:OPC6_LO] == OPC_INC_SKIP);
		is_or = (instr.word[OPC6_HI:OPC6_LO] == OPC_OR_LIT);
		is_jump = (instr.word[OPC6_HI:OPC3_LO] == OPC_JUMP);
		dec_addr = instr.word[FADDR_HI:0];
		dec_dest = instr.word[DEST_BIT];
		dec_lit8 = instr.word[LIT8_HI:0];
		dec_lit11 = instr.word[LIT11_HI:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// held operation for the read and execute steps

	logic op_dec;
	logic op_dest;
	logic next_op_dec;
	logic next_op_dest;

	always_comb
	begin
		next_op_dec = op_dec;
		next_op_dest = op_dest;
		if (accept && (state == SBE_IDLE) && (is_dec || is_inc))
		begin
			next_op_dec = is_dec;
			next_op_dest = dec_dest;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_dec <= 1'b0;
			op_dest <= DEST_ACC;
		end
		else
		begin
			op_dec <= next_op_dec;
			op_dest <= next_op_dest;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// arithmetic and jump target

	logic [DATA_W-1:0] step_result;
	logic step_zero;
	logic [PC_W-1:0] jump_target;

	sbe_incdec #(
		.W(DATA_W)
	) u_incdec (
		.operand(file_rdata),
		.decrement(op_dec),
		.result(step_result),
		.is_zero(step_zero)
	);

	sbe_pc_build u_pc_build (
		.literal(dec_lit11),
		.pc_high_latch(pc_high_latch),
		.target(jump_target)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	logic next_instr_ready;

	always_comb
	begin
		next_state = state;
		case (state)
			SBE_IDLE:
			begin
				if (accept)
				begin
					if (is_dec || is_inc)
						next_state = SBE_READ;
					else if (is_jump)
						next_state = SBE_DISCARD;
					else
						next_state = SBE_IDLE;
				end
			end
			SBE_READ:
			begin
				next_state = SBE_EXEC;
			end
			SBE_EXEC:
			begin
				if (step_zero)
					next_state = SBE_DISCARD;
				else
					next_state = SBE_IDLE;
			end
			SBE_DISCARD:
			begin
				if (accept)
					next_state = SBE_IDLE;
			end
			default:
			begin
				next_state = SBE_IDLE;
			end
		endcase
		next_instr_ready = (next_state == SBE_IDLE) || (next_state == SBE_DISCARD);
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= SBE_IDLE;
			instr_ready <= 1'b0;
		end
		else
		begin
			state <= next_state;
			instr_ready <= next_instr_ready;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// file register requests

	sbe_file_req_s next_file_req;

	always_comb
	begin
		next_file_req = file_req;
		next_file_req.re = 1'b0;
		next_file_req.we = 1'b0;
		case (state)
			SBE_IDLE:
			begin
				if (accept && (is_dec || is_inc))
				begin
					next_file_req.re = 1'b1;
					next_file_req.addr = dec_addr;
				end
			end
			SBE_READ:
			begin
				next_file_req.re = 1'b1;
			end
			SBE_EXEC:
			begin
				if (op_dest == DEST_FILE)
				begin
					next_file_req.we = 1'b1;
					next_file_req.wdata = step_result;
				end
			end
			SBE_DISCARD:
			begin
				next_file_req.re = 1'b0;
			end
			default:
			begin
				next_file_req.re = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			file_req.re <= 1'b0;
			file_req.we <= 1'b0;
			file_req.addr <= FADDR_RST;
			file_req.wdata <= ACC_RST;
		end
		else
		begin
			file_req <= next_file_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// program counter load

	sbe_pc_s next_pc_out;

	always_comb
	begin
		next_pc_out.load = 1'b0;
		next_pc_out.target = pc_out.target;
		if ((state == SBE_IDLE) && accept && is_jump)
		begin
			next_pc_out.load = 1'b1;
			next_pc_out.target = jump_target;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pc_out.load <= 1'b0;
			pc_out.target <= PC_RST;
		end
		else
		begin
			pc_out <= next_pc_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// working register and zero flag

	logic [DATA_W-1:0] next_acc;
	logic next_zero_flag;
	logic next_zero_we;
	logic [DATA_W-1:0] or_result;

	always_comb
	begin
		next_acc = acc;
		next_zero_flag = zero_flag;
		next_zero_we = 1'b0;
		or_result = acc | dec_lit8;
		if ((state == SBE_IDLE) && accept && is_or)
		begin
			next_acc = or_result;
			next_zero_flag = (or_result == '0);
			next_zero_we = 1'b1;
		end
		else if ((state == SBE_EXEC) && (op_dest == DEST_ACC))
		begin
			next_acc = step_result;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc <= ACC_RST;
			zero_flag <= ZERO_RST;
			zero_we <= 1'b0;
		end
		else
		begin
			acc <= next_acc;
			zero_flag <= next_zero_flag;
			zero_we <= next_zero_we;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slot reporting

	logic next_nop_slot;
	logic next_unknown_op;

	always_comb
	begin
		// the word fetched behind a taken skip or a jump is dropped
		next_nop_slot = (state == SBE_DISCARD) && accept;
		next_unknown_op = (state == SBE_IDLE) && accept && !(is_dec || is_inc || is_jump || is_or);
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			nop_slot <= 1'b0;
			unknown_op <= 1'b0;
		end
		else
		begin
			nop_slot <= next_nop_slot;
			unknown_op <= next_unknown_op;
		end
	end

endmodule

`default_nettype wire

//--- src/sbe_pkg.sv
// shared constants and carrier types of the skip, branch and or-literal execution unit
//
// Notes on behaviour
// - decrement reads 7-bit addressed file register
// - destination bit 0 to acc, 1 to file
// - zero decrement result turns next slot into nop
// - nonzero result lets the next instruction run
// - increment reads addressed file register, adds one
// - zero increment result turns next slot into nop
// - jump loads 11-bit literal into pc low bits
// - jump takes pc bits 14:11 from latch 6:3
// - jump occupies two instruction slots
// - or literal into acc, update zero flag
`default_nettype none

package sbe_pkg;

	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 15;
	localparam int LATCH_W = 7;
	localparam int JUMP_LIT_W = 11;

	// opcode fields and patterns
	localparam int OPC6_HI = 13;
	localparam int OPC6_LO = 8;
	localparam int OPC3_LO = 11;
	localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
	localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
	localparam logic [5:0] OPC_OR_LIT = 6'h38;
	localparam logic [2:0] OPC_JUMP = 3'h5;

	// operand fields
	localparam int DEST_BIT = 7;
	localparam int FADDR_HI = 6;
	localparam int LIT8_HI = 7;
	localparam int LIT11_HI = 10;
	localparam int LATCH_SEL_HI = 6;
	localparam int LATCH_SEL_LO = 3;

	// destination encodings
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic ZERO_RST = 1'b0;
	localparam logic [6:0] FADDR_RST = 7'h00;
	localparam logic [14:0] PC_RST = 15'h0000;

	typedef struct packed {
		logic valid;
		logic [INSTR_W-1:0] word;
	} sbe_instr_s;

	typedef struct packed {
		logic re;
		logic we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sbe_file_req_s;

	typedef struct packed {
		logic load;
		logic [PC_W-1:0] target;
	} sbe_pc_s;

	typedef enum logic [1:0] {
		SBE_IDLE = 2'b00,
		SBE_READ = 2'b01,
		SBE_EXEC = 2'b11,
		SBE_DISCARD = 2'b10
	} sbe_state_e;

endpackage

`default_nettype wire

//--- src/sbe_incdec.sv
// increment or decrement by one with a zero detect
`default_nettype none

module sbe_incdec #(
	parameter int W = 8
) (
	// operand
	input wire logic [W-1:0] operand,
	input wire logic decrement,
	// result
	output logic [W-1:0] result,
	output logic is_zero
);

	always_comb
	begin
		if (decrement)
			result = operand - W'(1);
		else
			result = operand + W'(1);
		is_zero = (result == '0);
	end

endmodule

`default_nettype wire

//--- src/sbe_pc_build.sv
// jump target assembly from the literal and the high-address latch
`default_nettype none

module sbe_pc_build
	import sbe_pkg::*;
(
	// sources
	input wire logic [sbe_pkg::JUMP_LIT_W-1:0] literal,
	input wire logic [sbe_pkg::LATCH_W-1:0] pc_high_latch,
	// target
	output logic [sbe_pkg::PC_W-1:0] target
);

	always_comb
	begin
		target = {pc_high_latch[LATCH_SEL_HI:LATCH_SEL_LO], literal};
	end

endmodule

`default_nettype wire

//--- bench/sbe_exec_unit_properties.sv
// concurrent checks on the execution unit ports
`default_nettype none
module sbe_exec_unit_chk
	import sbe_pkg::*;
(
	// watched ports
	input wire logic sys_clk,
	input wire logic resetn,
	input wire sbe_pkg::sbe_instr_s instr,
	input wire logic instr_ready,
	input wire sbe_pkg::sbe_file_req_s file_req,
	input wire logic [7:0] file_rdata,
	input wire logic [6:0] pc_high_latch,
	input wire sbe_pkg::sbe_pc_s pc_out,
	input wire logic [7:0] acc,
	input wire logic zero_flag,
	input wire logic zero_we,
	input wire logic nop_slot,
	input wire logic unknown_op
);
	logic take;
	logic dec_q;
	assign take = instr.valid && instr_ready;
	// inc and dec differ in word bit 10; held while the unit refuses words
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
			dec_q <= 1'b0;
		else if (take)
			dec_q <= !instr.word[10];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_read;
		file_req.re && !instr_ready ##1 file_req.re ##1 !file_req.re;
	endsequence
	a_zero_update: assert property (zero_we |-> zero_flag == (acc == 8'h00))
		else $error("zero flag wrong");
	a_or_value: assert property (zero_we |-> $past(instr.word[13:8]) == OPC_OR_LIT &&
		acc == ($past(acc) | $past(instr.word[7:0]))) else $error("or result wrong");
	a_jump_target: assert property (pc_out.load |->
		pc_out.target == {$past(pc_high_latch[6:3]), $past(instr.word[10:0])}) else $error("jump target wrong");
	a_jump_taken: assert property (take && instr.word[13:11] == OPC_JUMP |=> pc_out.load || nop_slot)
		else $error("jump lost");
	a_flags_hold: assert property (!zero_we |-> $stable(zero_flag))
		else $error("flag moved");
	a_file_write: assert property (file_req.we |->
		file_req.wdata == (dec_q ? 8'($past(file_rdata) - 1) : 8'($past(file_rdata) + 1))) else $error("write wrong");
	a_read_steps: assert property ($rose(file_req.re) |-> s_read)
		else $error("read steps wrong");
	a_nop_alone: assert property (nop_slot |-> $past(take) && !(zero_we || pc_out.load || file_req.re))
		else $error("dropped slot acted");
endmodule
bind sbe_exec_unit sbe_exec_unit_chk u_chk (.sys_clk, .resetn, .instr, .instr_ready, .file_req, .file_rdata,
	.pc_high_latch, .pc_out, .acc, .zero_flag, .zero_we, .nop_slot, .unknown_op);
`default_nettype wire

//--- bench/skip_branch_or_exec_unit_tb.sv
// self-checking bench of the execution unit
`default_nettype none
module skip_branch_or_exec_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sbe_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	sbe_instr_s instr = '0;
	logic [6:0] pc_high_latch = 7'h00;
	logic [7:0] file_rdata = 8'h00;
	logic instr_ready, zero_flag, zero_we, nop_slot, unknown_op;
	logic [7:0] acc;
	sbe_file_req_s file_req;
	sbe_pc_s pc_out;
	logic [7:0] mem [128];
	logic [4:0] seen;
	logic seen_clr = 1'b1;
	int miscompares = 0, n_checks = 0, acc_m = 0, zf_m = 0, skip_m = 0;
	initial
		forever #2 sys_clk = ~sys_clk;
	sbe_exec_unit u_dut (.sys_clk, .resetn, .instr, .instr_ready, .file_req, .file_rdata, .pc_high_latch,
		.pc_out, .acc, .zero_flag, .zero_we, .nop_slot, .unknown_op);
	// file register stand-in, data ready well before use
	always @(negedge sys_clk)
		file_rdata <= mem[file_req.addr];
	always @(posedge sys_clk)
		seen <= seen_clr ? 5'h00 : (seen | {unknown_op, nop_slot, file_req.we, pc_out.load, zero_we});
	task automatic chk(input logic [15:0] s, input int e);
		n_checks++;
		if (s !== 16'(e))
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, 16'(e));
		end
	endtask
	task automatic give_verdict;
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic issue(input logic [13:0] w);
		int n;
		@(negedge sys_clk);
		for (n = 0; instr_ready !== 1'b1; n++)
		begin
			if (n == 20)
			begin
				miscompares++;
				give_verdict;
			end
			@(negedge sys_clk);
		end
		seen_clr = 1'b1;
		instr = {1'b1, w};
		pc_high_latch = 7'($urandom);
		@(negedge sys_clk);
		instr.valid = 1'b0;
		seen_clr = 1'b0;
		repeat (6) @(negedge sys_clk);
	endtask
	initial
	begin
		logic [13:0] w;
		int op, a, r;
		void'($urandom(27));
		for (a = 0; a < 128; a++)
			mem[a] = 8'($urandom);
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		for (int i = 0; i < 200; i++)
		begin
			op = $urandom_range(4);
			w = 14'($urandom);
			a = w[6:0];
			case (op)
				0: w[13:8] = OPC_DEC_SKIP;
				1: w[13:8] = OPC_INC_SKIP;
				2: w = {OPC_OR_LIT, ($urandom_range(3) != 0) ? w[7:0] : 8'h00};
				3: w[13:11] = OPC_JUMP;
				default: w[13:8] = 6'h3f;
			endcase
			if (op < 2 && $urandom_range(1))
				mem[a] = op ? 8'hff : 8'h01;
			issue(w);
			if (skip_m)
			begin
				chk(seen, 8);
				skip_m = 0;
			end
			else if (op == 2)
			begin
				acc_m |= w[7:0];
				zf_m = acc_m == 0;
				chk(seen, 1);
			end
			else if (op == 3)
			begin
				chk(pc_out.target, {pc_high_latch[6:3], w[10:0]});
				chk(seen, 2);
				skip_m = 1;
			end
			else if (op < 2)
			begin
				r = (mem[a] + (op ? 1 : -1)) & 255;
				skip_m = r == 0;
				if (w[7])
				begin
					mem[a] = 8'(r);
					chk(seen, 4);
					chk({file_req.addr, file_req.wdata}, a * 256 + r);
				end
				else
				begin
					acc_m = r;
					chk(seen, 0);
				end
			end
			else
				chk(seen, 16);
			chk(acc, acc_m);
			chk(zero_flag, zf_m);
		end
		give_verdict;
	end
endmodule
`default_nettype wire
